// ---- src/dmc_map.svh ----
// register indices, field positions, reset values and counts of the mode-control block
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

`define DMC_IDX_CTRL 7'h14
`define DMC_IDX_STAT 7'h15
`define DMC_CTRL_RST 8'h00
`define DMC_STAT_RSVD 6'h00
`define DMC_STAT_LEFT_BIT 0
`define DMC_STAT_RIGHT_BIT 1
`define DMC_OSR_64 2'h0
`define DMC_OSR_RSVD 2'h1
`define DMC_OSR_128 2'h2
`define DMC_OSR_32 2'h3
`define DMC_RATIO_64 8'h40
`define DMC_RATIO_128 8'h80
`define DMC_RATIO_32 8'h20
`define DMC_ZERO_RUN 1024
`define DMC_WORD_BITS 16
`define DMC_HDR_BITS 8
`define DMC_RW_READ 1'h1
`define DMC_SAMPLE_BITS 24

`endif

// ---- src/dmc_pkg.sv ----
// types shared by the mode-control block and its serial control port
`include "dmc_map.svh"

package dmc_pkg;

    typedef struct packed {
        logic [`DMC_SAMPLE_BITS-1:0] left;
        logic [`DMC_SAMPLE_BITS-1:0] right;
    } dmc_stereo_t;

    typedef struct packed {
        logic order_sel;
        logic sys_reset_req;
        logic mode_reset_req;
        logic filter_bypass;
        logic single_channel_mode;
        logic channel_pick;
        logic [1:0] oversample_ratio_sel;
    } dmc_ctrl_t;

    typedef struct packed {
        logic stb;
        logic [6:0] idx;
        logic [7:0] data;
    } dmc_wr_t;

    typedef enum logic {SP_IDLE, SP_SHIFT} dmc_sp_state_t;

endpackage

// ---- src/dmc_serial_port.sv ----
// serial control port: frames 16-bit control words into register writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"

module dmc_serial_port
    import dmc_pkg::*;
(
    input wire logic clk_sys,          // system clock
    input wire logic reset,            // synchronous reset, active high
    input wire logic ctl_cs_n,         // port select pin, active low
    input wire logic ctl_sclk,         // port shift clock pin
    input wire logic ctl_sdi,          // port data in pin
    output logic ctl_sdo,              // port data out
    output logic ctl_sdo_oe,           // data out enable, high while driving
    output logic [6:0] rd_idx,         // index being read
    input wire logic [7:0] rd_data,    // read value for rd_idx
    output dmc_wr_t wr                 // one-cycle write request
);

    // ==============================================================
    // pin synchronisers
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    logic sclk_prev_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    pin_meta_ff[gi] <= 1'h1;
                    pin_sync_ff[gi] <= 1'h1;
                end else begin
                    pin_meta_ff[gi] <= (gi == 0) ? ctl_cs_n : ((gi == 1) ? ctl_sclk : ctl_sdi);
                    pin_sync_ff[gi] <= pin_meta_ff[gi];
                end
            end
        end
    endgenerate

    wire logic cs_n_s = pin_sync_ff[0];
    wire logic sclk_s = pin_sync_ff[1];
    wire logic sdi_s = pin_sync_ff[2];
    wire logic sclk_rise = sclk_s & ~sclk_prev_ff;
    wire logic sclk_fall = ~sclk_s & sclk_prev_ff;

    // ==============================================================
    // framing
    dmc_sp_state_t state_ff;
    logic [4:0] bit_cnt_ff;
    logic [6:0] shift_ff;
    logic [7:0] hdr_ff;
    logic [7:0] out_sh_ff;
    logic sdo_ff;
    logic oe_ff;
    dmc_wr_t wr_ff;

    wire logic hdr_done = (bit_cnt_ff == 5'(`DMC_HDR_BITS - 1));
    wire logic word_done = (bit_cnt_ff == 5'(`DMC_WORD_BITS - 1));
    wire logic is_read = (hdr_ff[7] == `DMC_RW_READ);
    wire logic in_data = (bit_cnt_ff >= 5'(`DMC_HDR_BITS));
    wire logic first_data = (bit_cnt_ff == 5'(`DMC_HDR_BITS));
    // a shift edge is only taken once the select has been seen for a full cycle
    wire logic framing = (state_ff == SP_SHIFT);

    assign rd_idx = hdr_ff[6:0];
    assign ctl_sdo = sdo_ff;
    assign ctl_sdo_oe = oe_ff;
    assign wr = wr_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclk_prev_ff <= 1'h1;
        end else begin
            sclk_prev_ff <= sclk_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || cs_n_s) begin
            state_ff <= SP_IDLE;
            bit_cnt_ff <= 5'h00;
            shift_ff <= 7'h00;
            hdr_ff <= 8'h00;
            out_sh_ff <= 8'h00;
            sdo_ff <= 1'h0;
            oe_ff <= 1'h0;
            wr_ff <= '0;
        end else begin
            state_ff <= SP_SHIFT;
            wr_ff.stb <= 1'h0;
            if (sclk_rise && framing && bit_cnt_ff < 5'(`DMC_WORD_BITS)) begin
                shift_ff <= {shift_ff[5:0], sdi_s};
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                if (hdr_done) begin
                    hdr_ff <= {shift_ff[6:0], sdi_s};
                end
                // the top bit of the word chooses write or read
                if (word_done && !is_read) begin
                    wr_ff.stb <= 1'h1;
                    wr_ff.idx <= hdr_ff[6:0];
                    wr_ff.data <= {shift_ff[6:0], sdi_s};
                end
            end
            // read data leaves msb first on falling shift edges
            if (sclk_fall && in_data && is_read) begin
                oe_ff <= 1'h1;
                if (first_data) begin
                    sdo_ff <= rd_data[7];
                    out_sh_ff <= {rd_data[6:0], 1'h0};
                end else begin
                    sdo_ff <= out_sh_ff[7];
                    out_sh_ff <= {out_sh_ff[6:0], 1'h0};
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- src/dmc_top.sv ----
// mode control and zero-detect status of the stereo converter, behind the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"

// Operation
// - bypass bit 0 uses interpolator, 1 skips it
// - single_channel_mode bit 1 feeds both channels one input
// - pick bit chooses left/right, single_channel_mode only
// - ratio field: 00=64x, 10=128x, 11=32x
// - one-bit mode: field sets FIR bit clock
// - zero flag after 1024 zero samples
// - each zero flag drives its own pin
// - status bit0 left flag, bit1 right flag
// - word msb 0 writes, 1 reads
module dmc_top
    import dmc_pkg::*;
#(
    parameter int ZERO_RUN = `DMC_ZERO_RUN      // zero samples before a flag sets
)(
    input wire logic clk_sys,                  // system clock, 20 MHz
    input wire logic reset,                    // synchronous reset, active high
    input wire logic ctl_cs_n,                 // control port select pin, active low
    input wire logic ctl_sclk,                 // control port shift clock pin
    input wire logic ctl_sdi,                  // control port data in pin
    output logic ctl_sdo,                      // control port data out
    output logic ctl_sdo_oe,                   // data out enable, high while driving
    input wire logic sample_valid,             // one pulse per sample period
    input wire dmc_stereo_t interp_data,       // samples from the interpolation filter
    input wire dmc_stereo_t ext_data,          // samples from the bypass input
    input wire logic onebit_mode,              // one-bit stream input selected
    output dmc_stereo_t mod_data,              // samples to the modulators
    output logic mod_valid,                    // mod_data updated this cycle
    output logic filter_bypass,                // interpolation filter skipped
    output logic [7:0] mod_ratio,              // modulator oversampling ratio
    output logic [7:0] fir_bck_ratio,          // bit-clock speed for the output FIR
    output logic left_zero_pin,                // left channel zero flag
    output logic right_zero_pin                // right channel zero flag
);

    localparam int CW = $clog2(ZERO_RUN + 1);

    // ==============================================================
    // ratio decode, shared by modulator and one-bit paths
    function automatic logic [7:0] ratio_of(input logic [1:0] sel);
        logic [7:0] r;
        r = `DMC_RATIO_64;
        case (sel)
            `DMC_OSR_128: r = `DMC_RATIO_128;
            `DMC_OSR_32: r = `DMC_RATIO_32;
            default: r = `DMC_RATIO_64;
        endcase
        return r;
    endfunction

    // ==============================================================
    // control port and registers
    dmc_ctrl_t ctrl_ff;
    logic [1:0] zero_flag_ff;
    logic [6:0] rd_idx;
    dmc_wr_t wr;

    // status reads back the live flags, reserved bits as zero
    wire logic [7:0] stat_value = {`DMC_STAT_RSVD, zero_flag_ff};
    wire logic [7:0] rd_data = (rd_idx == `DMC_IDX_CTRL) ? 8'(ctrl_ff) :
                               (rd_idx == `DMC_IDX_STAT) ? stat_value : 8'h00;
    wire logic ctrl_wr = wr.stb && (wr.idx == `DMC_IDX_CTRL);

    dmc_serial_port u_port (
        .clk_sys(clk_sys),
        .reset(reset),
        .ctl_cs_n(ctl_cs_n),
        .ctl_sclk(ctl_sclk),
        .ctl_sdi(ctl_sdi),
        .ctl_sdo(ctl_sdo),
        .ctl_sdo_oe(ctl_sdo_oe),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .wr(wr)
    );

    // only the control index is writable; the status index falls through
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff <= dmc_ctrl_t'(`DMC_CTRL_RST);
        end else if (ctrl_wr) begin
            ctrl_ff <= dmc_ctrl_t'(wr.data);
        end
    end

    // ==============================================================
    // sample path: source pick, then single_channel_mode fold
    wire dmc_stereo_t src = ctrl_ff.filter_bypass ? ext_data : interp_data;
    wire logic [`DMC_SAMPLE_BITS-1:0] single_channel_mode_pick =
        ctrl_ff.channel_pick ? src.right : src.left;
    wire dmc_stereo_t nxt_mod_data = ctrl_ff.single_channel_mode ?
        {single_channel_mode_pick, single_channel_mode_pick} : src;

    dmc_stereo_t mod_data_ff;
    logic mod_valid_ff;
    logic bypass_ff;
    logic [7:0] mod_ratio_ff;
    logic [7:0] fir_bck_ratio_ff;

    // in one-bit mode the modulator sits idle, so its ratio rests at default
    wire logic [7:0] nxt_mod_ratio = onebit_mode ? `DMC_RATIO_64 :
                                     ratio_of(ctrl_ff.oversample_ratio_sel);
    wire logic [7:0] nxt_fir_bck_ratio = onebit_mode ?
        ratio_of(ctrl_ff.oversample_ratio_sel) : `DMC_RATIO_64;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mod_data_ff <= '0;
            mod_valid_ff <= 1'h0;
            bypass_ff <= 1'h0;
            mod_ratio_ff <= `DMC_RATIO_64;
            fir_bck_ratio_ff <= `DMC_RATIO_64;
        end else begin
            mod_valid_ff <= sample_valid;
            if (sample_valid) begin
                mod_data_ff <= nxt_mod_data;
            end
            bypass_ff <= ctrl_ff.filter_bypass;
            mod_ratio_ff <= nxt_mod_ratio;
            fir_bck_ratio_ff <= nxt_fir_bck_ratio;
        end
    end

    assign mod_data = mod_data_ff;
    assign mod_valid = mod_valid_ff;
    assign filter_bypass = bypass_ff;
    assign mod_ratio = mod_ratio_ff;
    assign fir_bck_ratio = fir_bck_ratio_ff;

    // ==============================================================
    // zero detection, one run counter per channel
    logic [CW-1:0] zero_cnt_ff [2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_zero
            wire logic [`DMC_SAMPLE_BITS-1:0] ch_data = (ch == 0) ? src.left : src.right;
            wire logic is_zero = (ch_data == '0);
            // counter saturates so a long silence cannot wrap the flag off
            wire logic at_run = (zero_cnt_ff[ch] == CW'(ZERO_RUN));
            wire logic [CW-1:0] nxt_cnt = !is_zero ? '0 :
                                          at_run ? zero_cnt_ff[ch] : zero_cnt_ff[ch] + CW'(1);
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    zero_cnt_ff[ch] <= '0;
                    zero_flag_ff[ch] <= 1'h0;
                end else if (sample_valid) begin
                    zero_cnt_ff[ch] <= nxt_cnt;
                    zero_flag_ff[ch] <= (nxt_cnt == CW'(ZERO_RUN));
                end
            end
        end
    endgenerate

    assign left_zero_pin = zero_flag_ff[`DMC_STAT_LEFT_BIT];
    assign right_zero_pin = zero_flag_ff[`DMC_STAT_RIGHT_BIT];

    // ==============================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_bypass_path;
        sample_valid && ctrl_ff.filter_bypass && !ctrl_ff.single_channel_mode
            |=> mod_data == $past(ext_data) && filter_bypass;
    endproperty
    a_bypass_path: assert property (p_bypass_path) else $error("bypass path wrong");

    property p_filter_path;
        sample_valid && !ctrl_ff.filter_bypass && !ctrl_ff.single_channel_mode
            |=> mod_data == $past(interp_data) && !filter_bypass;
    endproperty
    a_filter_path: assert property (p_filter_path) else $error("filter path wrong");

    property p_single_channel_mode_left;
        sample_valid && ctrl_ff.single_channel_mode && !ctrl_ff.channel_pick
            && !ctrl_ff.filter_bypass
            |=> mod_data.left == $past(interp_data.left) && mod_data.right == mod_data.left;
    endproperty
    a_single_channel_mode_left: assert property (p_single_channel_mode_left) else $error("single_channel_mode left wrong");

    property p_single_channel_mode_right;
        sample_valid && ctrl_ff.single_channel_mode && ctrl_ff.channel_pick
            && !ctrl_ff.filter_bypass
            |=> mod_data.right == $past(interp_data.right) && mod_data.left == mod_data.right;
    endproperty
    a_single_channel_mode_right: assert property (p_single_channel_mode_right) else $error("single_channel_mode right wrong");

    property p_ratio_128;
        !onebit_mode && ctrl_ff.oversample_ratio_sel == `DMC_OSR_128
            |=> mod_ratio == `DMC_RATIO_128;
    endproperty
    a_ratio_128: assert property (p_ratio_128) else $error("ratio 128 wrong");

    property p_bck_32;
        onebit_mode && ctrl_ff.oversample_ratio_sel == `DMC_OSR_32
            |=> fir_bck_ratio == `DMC_RATIO_32 && mod_ratio == `DMC_RATIO_64;
    endproperty
    a_bck_32: assert property (p_bck_32) else $error("bit clock speed wrong");

    property p_zero_clears;
        sample_valid && src.left != '0 |=> !left_zero_pin ##1 !left_zero_pin || sample_valid;
    endproperty
    a_zero_clears: assert property (p_zero_clears) else $error("left flag stays set");

    property p_zero_sets;
        sample_valid && src.right == '0 && zero_cnt_ff[1] == CW'(ZERO_RUN - 1)
            |=> right_zero_pin;
    endproperty
    a_zero_sets: assert property (p_zero_sets) else $error("right flag not set");

    property p_status_view;
        rd_idx == `DMC_IDX_STAT |-> rd_data == {6'h00, right_zero_pin, left_zero_pin};
    endproperty
    a_status_view: assert property (p_status_view) else $error("status read wrong");

    property p_status_ro;
        wr.stb && wr.idx == `DMC_IDX_STAT |=> $stable(ctrl_ff);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write took");

    property p_ctrl_write;
        ctrl_wr |=> 8'(ctrl_ff) == $past(wr.data);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

endmodule
`default_nettype wire

// ---- dv/dmc_host_model.sv ----
// host controller model that speaks the serial control port
`timescale 1ns/1ps
`default_nettype none

module dmc_host_model (
    input wire logic clk_sys,    // system clock, paces every shift phase
    output logic ctl_cs_n,       // port select, active low
    output logic ctl_sclk,       // shift clock, rests high between words
    output logic ctl_sdi,        // serial data towards the port
    input wire logic ctl_sdo,    // serial data from the port
    input wire logic ctl_sdo_oe  // high while the port drives ctl_sdo
);
    logic sdo_last = 1'b0;
    logic sdo_wire;

    // a released line must not look like it still holds the last bit
    assign sdo_wire = ctl_sdo_oe ? ctl_sdo : ~sdo_last;

    always @(posedge clk_sys) begin
        if (ctl_sdo_oe) begin
            sdo_last <= ctl_sdo;
        end
    end

    initial begin
        ctl_cs_n = 1'b1;
        ctl_sclk = 1'b1;
        ctl_sdi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ==========================================================
    // one 16-bit word, header first; phases of 5 cycles leave margin over the 3 needed
    task automatic xfer(input logic rd, input logic [6:0] idx, input logic [7:0] wd,
                        output logic [7:0] rdv);
        logic [15:0] word;
        word = {rd, idx, wd};
        rdv = 8'h00;
        wait_clk(1);
        ctl_cs_n = 1'b0;
        wait_clk(4);
        for (int i = 15; i >= 0; i--) begin
            ctl_sclk = 1'b0;
            ctl_sdi = word[i];
            wait_clk(5);
            ctl_sclk = 1'b1;
            if (i < 8) begin
                rdv[i] = sdo_wire;
            end
            wait_clk(5);
        end
        wait_clk(4);
        ctl_cs_n = 1'b1;
        ctl_sdi = ~ctl_sdi;
        wait_clk(8);
    endtask
endmodule

`default_nettype wire

// ---- dv/test_dac_mode_control_status.sv ----
// self-checking bench for the mode-control and zero-detect block
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"

module test_dac_mode_control_status;
    import dmc_pkg::*;
    // short zero run keeps the flag tests brief
    localparam int RUN = 4;
    localparam int LIMIT = 30000;
    localparam logic [7:0] RATIO [4] = '{`DMC_RATIO_64, `DMC_RATIO_64, `DMC_RATIO_128,
                                         `DMC_RATIO_32};
    logic clk_sys, reset, ctl_cs_n, ctl_sclk, ctl_sdi, ctl_sdo, ctl_sdo_oe;
    logic sample_valid, onebit_mode, mod_valid, filter_bypass, left_zero_pin, right_zero_pin;
    dmc_stereo_t interp_data, ext_data, mod_data;
    logic [7:0] mod_ratio, fir_bck_ratio, rd;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    dmc_top #(.ZERO_RUN(RUN)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk),
        .ctl_sdi(ctl_sdi), .ctl_sdo(ctl_sdo), .ctl_sdo_oe(ctl_sdo_oe),
        .sample_valid(sample_valid), .interp_data(interp_data), .ext_data(ext_data),
        .onebit_mode(onebit_mode), .mod_data(mod_data), .mod_valid(mod_valid),
        .filter_bypass(filter_bypass), .mod_ratio(mod_ratio), .fir_bck_ratio(fir_bck_ratio),
        .left_zero_pin(left_zero_pin), .right_zero_pin(right_zero_pin)
    );
    dmc_host_model host_u (
        .clk_sys(clk_sys), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk), .ctl_sdi(ctl_sdi),
        .ctl_sdo(ctl_sdo), .ctl_sdo_oe(ctl_sdo_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            $display("MISMATCH at %0t: run did not finish in time", $time);
            end_sim();
        end
    end

    // ==========================================================
    // shared helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        host_u.xfer(1'b0, idx, d, rd);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp, input string what);
        host_u.xfer(1'b1, idx, 8'h00, rd);
        chk({40'h0, rd}, {40'h0, exp}, what);
    endtask

    // bypass input carries the inverse so the two paths never look alike
    task automatic send(input logic [23:0] l, input logic [23:0] r);
        interp_data = {l, r};
        ext_data = {~l, ~r};
        sample_valid = 1'h1;
        tick(1);
        sample_valid = 1'h0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk(filter_bypass, 1'h0, "bypass after reset");
        chk({mod_ratio, fir_bck_ratio}, {`DMC_RATIO_64, `DMC_RATIO_64}, "ratios");
        chk({left_zero_pin, right_zero_pin}, 2'h0, "zero pins after reset");
        rd_chk(`DMC_IDX_CTRL, `DMC_CTRL_RST, "control after reset");
        rd_chk(`DMC_IDX_STAT, 8'h00, "status after reset");
        $display("test reset done");
    endtask

    task automatic t_bypass();
        wr(`DMC_IDX_CTRL, 8'h10);
        chk(filter_bypass, 1'h1, "bypass set");
        send(24'h123456, 24'hABCDEF);
        chk(mod_valid, 1'h1, "sample pulse");
        chk(mod_data, {24'hEDCBA9, 24'h543210}, "bypass path");
        wr(`DMC_IDX_CTRL, 8'h00);
        send(24'h123456, 24'hABCDEF);
        chk(mod_data, {24'h123456, 24'hABCDEF}, "filter path stereo");
        $display("test bypass done");
    endtask

    task automatic t_single_channel_mode();
        wr(`DMC_IDX_CTRL, 8'h08);
        send(24'h111111, 24'h222222);
        chk(mod_data, {24'h111111, 24'h111111}, "single_channel_mode left");
        wr(`DMC_IDX_CTRL, 8'h0C);
        rd_chk(`DMC_IDX_CTRL, 8'h0C, "control readback");
        send(24'h111111, 24'h222222);
        chk(mod_data, {24'h222222, 24'h222222}, "single_channel_mode right");
        wr(`DMC_IDX_CTRL, 8'h04);
        send(24'h111111, 24'h222222);
        chk(mod_data, {24'h111111, 24'h222222}, "pick ignored in stereo");
        $display("test single_channel_mode done");
    endtask

    task automatic t_ratio();
        for (int i = 0; i < 4; i++) begin
            wr(`DMC_IDX_CTRL, {6'h00, 2'(i)});
            for (int m = 0; m < 2; m++) begin
                onebit_mode = m[0];
                tick(2);
                chk(mod_ratio, m ? `DMC_RATIO_64 : RATIO[i], "modulator ratio");
                chk(fir_bck_ratio, m ? RATIO[i] : `DMC_RATIO_64, "fir bit clock");
            end
        end
        onebit_mode = 1'b0;
        wr(`DMC_IDX_CTRL, 8'h00);
        $display("test ratio done");
    endtask

    task automatic t_zero();
        // a spare cycle between samples keeps each strobe change in its own time step
        repeat (RUN - 1) begin
            send(24'h000000, 24'h000001);
            tick(1);
        end
        tick(2);
        chk({left_zero_pin, right_zero_pin}, 2'h0, "one short of run");
        send(24'h000000, 24'h000001);
        tick(2);
        chk({left_zero_pin, right_zero_pin}, 2'h2, "left run complete");
        rd_chk(`DMC_IDX_STAT, 8'h01, "status left only");
        repeat (RUN) begin
            send(24'h000000, 24'h000000);
            tick(1);
        end
        tick(2);
        chk({left_zero_pin, right_zero_pin}, 2'h3, "both runs complete");
        rd_chk(`DMC_IDX_STAT, 8'h03, "status both");
        wr(`DMC_IDX_STAT, 8'hFC);
        rd_chk(`DMC_IDX_STAT, 8'h03, "status write ignored");
        rd_chk(`DMC_IDX_CTRL, 8'h00, "control untouched");
        send(24'h000010, 24'h000000);
        tick(2);
        chk({left_zero_pin, right_zero_pin}, 2'h1, "left cleared");
        rd_chk(`DMC_IDX_STAT, 8'h02, "status right only");
        rd_chk(7'h33, 8'h00, "unmapped read");
        $display("test zero done");
    endtask

    initial begin
        reset = 1'b1;
        sample_valid = 1'b0;
        onebit_mode = 1'b0;
        interp_data = '0;
        ext_data = '0;
        tick(6);
        reset = 1'b0;
        tick(4);
        t_reset();
        t_bypass();
        t_single_channel_mode();
        t_ratio();
        t_zero();
        end_sim();
    end
endmodule

`default_nettype wire
